// File: core/otp_mwp_host.sv
// Host controller that drives multiple-word programming of an OTP memory.
//
// Contract
// - Open with writes AA at 555, 55 at 2AA, 20 at 555.
// - Each phase: first word at start location, rest at continue location.
// - End each phase by a write to a final location; data ignored.
// - Read status and confirm readiness before every data write.
// - After bit 5 is set, send read/reset before any other command.
// - Host ignores status bits undefined for the running command.
module otp_mwp_host
	import otp_host_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output wire logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output wire logic        wready,
	output wire logic [1:0]  bresp,
	output wire logic        bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output wire logic        arready,
	output wire logic [31:0] rdata,
	output wire logic [1:0]  rresp,
	output wire logic        rvalid,
	input  wire logic        rready,
	// Memory pins
	output pins_s            pins,
	input  wire logic [15:0] dq_in
);

	typedef enum logic [2:0] {
		S_IDLE, S_ISSUE, S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_GAP
	} state_e;

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	logic        aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [3:0]  aw_addr_q;
	logic [31:0] w_data_q, rdata_q;
	logic [3:0]  w_strb_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [20:0] addr_q;
	logic [15:0] data_q;
	logic        supply_en_q;

	state_e      st_q, st_d;
	cmd_e        cmd_q, cmd_d;
	logic [1:0]  step_q, step_d;
	logic [4:0]  cnt_q, cnt_d;
	pins_s       pins_q, pins_d;
	logic [7:0]  stat_q, stat_d;
	logic        err_q, err_d, sfault_q, sfault_d, tog_q, tog_d;
	logic        phase_q, phase_d, first_q, first_d;

	wire         wr_fire   = aw_full_q && w_full_q && !bvalid_q;
	wire         wr_full   = (w_strb_q == 4'hF);
	wire         wr_map    = aw_addr_q != STAT_OFS;
	wire         ctrl_wr   = wr_fire && wr_full && aw_addr_q == CTRL_OFS;
	wire cmd_e   req_cmd   = cmd_e'(w_data_q[2:0]);
	wire         idle      = st_q == S_IDLE;
	wire         req_legal = req_cmd != CMD_NONE && req_cmd <= CMD_POLL;
	wire         launch    = ctrl_wr && idle && req_legal &&
		(!err_q || req_cmd == CMD_RESET);
	wire         rd_fire   = arvalid && !rvalid_q;
	wire [31:0]  stat_word = {19'h0, phase_q, tog_q, sfault_q, err_q,
		!idle, stat_q};
	wire [31:0]  rd_mux    =
		(araddr == CTRL_OFS) ? {23'h0, supply_en_q, 8'h0} :
		(araddr == ADDR_OFS) ? {11'h0, addr_q} :
		(araddr == DATA_OFS) ? {16'h0, data_q} :
		(araddr == STAT_OFS) ? stat_word : 32'h0;
	wire         rd_map    = araddr[1:0] == 2'h0;

	assign awready = !aw_full_q;
	assign wready  = !w_full_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;
	assign pins    = pins_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q   <= 1'b0;
			w_full_q    <= 1'b0;
			bvalid_q    <= 1'b0;
			rvalid_q    <= 1'b0;
			aw_addr_q   <= 4'h0;
			w_data_q    <= 32'h0;
			w_strb_q    <= 4'h0;
			bresp_q     <= RESP_OKAY;
			rresp_q     <= RESP_OKAY;
			rdata_q     <= 32'h0;
			addr_q      <= 21'h0;
			data_q      <= 16'h0;
			supply_en_q <= 1'b0;
		end else begin
			if (awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (wr_fire) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
			if (wr_fire && wr_full && aw_addr_q == CTRL_OFS)
				supply_en_q <= w_data_q[SUPPLY_EN];
			if (wr_fire && wr_full && aw_addr_q == ADDR_OFS && idle)
				addr_q <= w_data_q[20:0];
			if (wr_fire && wr_full && aw_addr_q == DATA_OFS && idle)
				data_q <= w_data_q[15:0];
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_mux;
				rresp_q  <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end else if (rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Memory bus sequencer
	// ------------------------------------------------------------------
	logic        op_rd, op_wr;
	logic [20:0] op_addr;
	logic [15:0] op_data;
	wire  [20:0] final_addr = addr_q ^ (21'h1 << REGION_LSB);
	wire  [7:0]  rd_stat    = dq_in[7:0] & DEFINED_MASK;
	wire         rd_toggled = rd_stat[TOGGLE_BIT] != stat_q[TOGGLE_BIT];
	// After a finished operation a poll sees array data, so only a second
	// poll read whose activity bit moved is taken as status.
	wire         rd_trust   = cmd_q != CMD_POLL ||
		(step_q == 2'h1 && rd_toggled);

	always_comb begin
		op_rd   = 1'b0;
		op_wr   = 1'b0;
		op_addr = UNLOCK1_ADDR;
		op_data = 16'h0;
		case (cmd_q)
		CMD_SETUP: begin
			op_wr   = step_q < SETUP_STEPS;
			op_addr = (step_q == 2'h1) ? UNLOCK2_ADDR : UNLOCK1_ADDR;
			op_data = (step_q == 2'h0) ? UNLOCK1_DATA :
				(step_q == 2'h1) ? UNLOCK2_DATA : MWP_CODE;
		end
		CMD_WORD: begin
			// The start location also serves as the continue location;
			// the memory advances its own word address.
			op_rd   = step_q == 2'h0;
			op_wr   = step_q == 2'h1;
			op_addr = addr_q;
			op_data = data_q;
		end
		CMD_FINAL: begin
			op_wr   = step_q == 2'h0;
			op_addr = final_addr;
		end
		CMD_RESET: begin
			op_wr   = step_q == 2'h0;
			op_data = RESET_CODE;
		end
		CMD_POLL: begin
			op_rd   = step_q < 2'h2;
			op_addr = addr_q;
		end
		default: begin
			op_rd = 1'b0;
		end
		endcase
	end

	always_comb begin
		st_d     = st_q;
		cmd_d    = cmd_q;
		step_d   = step_q;
		cnt_d    = cnt_q - 5'h1;
		pins_d   = pins_q;
		stat_d   = stat_q;
		err_d    = err_q;
		sfault_d = sfault_q;
		tog_d    = tog_q;
		phase_d  = phase_q;
		first_d  = first_q;
		pins_d.supply_on = supply_en_q;
		case (st_q)
		S_IDLE: begin
			if (launch) begin
				cmd_d  = req_cmd;
				step_d = 2'h0;
				st_d   = S_ISSUE;
			end
		end
		S_ISSUE: begin
			pins_d.addr = op_addr;
			pins_d.dq   = op_data;
			if (op_wr) begin
				pins_d.dq_oe_n   = 1'b0;
				pins_d.chip_en_n = 1'b0;
				cnt_d            = WR_PULSE_CYC;
				st_d             = S_WR_LOW;
			end else if (op_rd) begin
				pins_d.chip_en_n = 1'b0;
				pins_d.read_en_n = 1'b0;
				cnt_d            = RD_ACC_CYC;
				st_d             = S_RD_LOW;
			end else begin
				st_d = S_IDLE;
				if (cmd_q == CMD_WORD)
					first_d = 1'b0;
				if (cmd_q == CMD_FINAL) begin
					phase_d = !phase_q;
					first_d = 1'b1;
				end
				if (cmd_q == CMD_RESET) begin
					err_d    = 1'b0;
					sfault_d = 1'b0;
					phase_d  = 1'b0;
					first_d  = 1'b1;
				end
			end
		end
		S_WR_LOW: begin
			if (cnt_q == 5'h1) begin
				pins_d.chip_en_n = 1'b1;
				cnt_d            = WR_GAP_CYC;
				st_d             = S_WR_HIGH;
			end
		end
		S_WR_HIGH: begin
			if (cnt_q == 5'h1) begin
				pins_d.dq_oe_n = 1'b1;
				step_d         = step_q + 2'h1;
				st_d           = S_ISSUE;
			end
		end
		S_RD_LOW: begin
			if (cnt_q == 5'h1) begin
				pins_d.chip_en_n = 1'b1;
				pins_d.read_en_n = 1'b1;
				stat_d   = rd_stat;
				tog_d    = rd_toggled;
				err_d    = err_q || (rd_trust && rd_stat[FAIL_BIT]);
				sfault_d = sfault_q ||
					(rd_trust && rd_stat[SUPPLY_BIT]);
				cnt_d    = RD_GAP_CYC;
				st_d     = S_RD_GAP;
			end
		end
		S_RD_GAP: begin
			if (cnt_q == 5'h1) begin
				st_d = S_ISSUE;
				if (cmd_q != CMD_WORD)
					step_d = step_q + 2'h1;
				else if (stat_q[FAIL_BIT])
					step_d = 2'h2;
				else if (!stat_q[WAIT_BIT])
					step_d = 2'h1;
			end
		end
		default: begin
			st_d = S_IDLE;
		end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q     <= S_IDLE;
			cmd_q    <= CMD_NONE;
			step_q   <= 2'h0;
			cnt_q    <= 5'h0;
			pins_q   <= '{addr: 21'h0, dq: 16'h0, dq_oe_n: 1'b1,
				chip_en_n: 1'b1, read_en_n: 1'b1, supply_on: 1'b0};
			stat_q   <= 8'h0;
			err_q    <= 1'b0;
			sfault_q <= 1'b0;
			tog_q    <= 1'b0;
			phase_q  <= 1'b0;
			first_q  <= 1'b1;
		end else begin
			st_q     <= st_d;
			cmd_q    <= cmd_d;
			step_q   <= step_d;
			cnt_q    <= cnt_d;
			pins_q   <= pins_d;
			stat_q   <= stat_d;
			err_q    <= err_d;
			sfault_q <= sfault_d;
			tog_q    <= tog_d;
			phase_q  <= phase_d;
			first_q  <= first_d;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic ce_prev_q;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ce_prev_q <= 1'b1;
		else
			ce_prev_q <= pins_q.chip_en_n;
	end

	wire wr_start = ce_prev_q && !pins_q.chip_en_n && !pins_q.dq_oe_n;

	setup_words_a: assert property (
		wr_start && cmd_q == CMD_SETUP |->
		(step_q != 2'h0 || (pins_q.addr == UNLOCK1_ADDR &&
			pins_q.dq == UNLOCK1_DATA)) &&
		(step_q != 2'h1 || (pins_q.addr == UNLOCK2_ADDR &&
			pins_q.dq == UNLOCK2_DATA)) &&
		(step_q != 2'h2 || pins_q.dq == MWP_CODE))
		else $error("setup word wrong");
	word_region_a: assert property (
		wr_start && cmd_q == CMD_WORD |->
		pins_q.addr[20:REGION_LSB] == addr_q[20:REGION_LSB] &&
		pins_q.dq == data_q)
		else $error("word write outside start region");
	final_phase_a: assert property (
		wr_start && cmd_q == CMD_FINAL |->
		pins_q.addr[20:REGION_LSB] != addr_q[20:REGION_LSB]
		##[1:20] $changed(phase_q))
		else $error("final write did not end the phase");
	poll_first_a: assert property (
		wr_start && cmd_q == CMD_WORD |->
		!stat_q[WAIT_BIT] && !stat_q[FAIL_BIT])
		else $error("word written without ready status");
	reset_only_a: assert property (
		err_q && ctrl_wr && req_cmd != CMD_RESET && idle |=> idle)
		else $error("command started while error pending");
	status_mask_a: assert property (
		st_q == S_RD_GAP |-> (stat_q & ~DEFINED_MASK) == 8'h0)
		else $error("undefined status bit kept");
	write_pulse_a: assert property (
		wr_start |-> !pins_q.chip_en_n [*5] ##1 pins_q.chip_en_n)
		else $error("chip enable write pulse wrong");

	setup_done_c: cover property (
		cmd_q == CMD_SETUP && st_q == S_ISSUE && step_q == SETUP_STEPS);
	word_done_c: cover property (wr_start && cmd_q == CMD_WORD);
	fail_seen_c: cover property ($rose(err_q));

endmodule : otp_mwp_host

// File: inc/otp_host_pkg.sv
// Constants, types and register map of the one-time-programmable memory host.
package otp_host_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ       = 100;
	localparam int T_WR_PULSE_NS = 50;
	localparam int T_WR_GAP_NS   = 50;
	localparam int T_RD_ACC_NS   = 110;
	localparam int T_RD_GAP_NS   = 30;
	localparam logic [4:0] WR_PULSE_CYC =
		5'((T_WR_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] WR_GAP_CYC =
		5'((T_WR_GAP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] RD_ACC_CYC =
		5'((T_RD_ACC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] RD_GAP_CYC =
		5'((T_RD_GAP_NS * CLK_MHZ + 999) / 1000);

	// ------------------------------------------------------------------
	// Memory command words and status bits
	// ------------------------------------------------------------------
	localparam logic [20:0] UNLOCK1_ADDR = 21'h000555;
	localparam logic [20:0] UNLOCK2_ADDR = 21'h0002AA;
	localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
	localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
	localparam logic [15:0] MWP_CODE     = 16'h0020;
	localparam logic [15:0] RESET_CODE   = 16'h00F0;
	localparam int          REGION_LSB   = 17;
	localparam logic [1:0]  SETUP_STEPS  = 2'h3;
	localparam int          TOGGLE_BIT   = 6;
	localparam int          FAIL_BIT     = 5;
	localparam int          SUPPLY_BIT   = 4;
	localparam int          WAIT_BIT     = 0;
	localparam logic [7:0]  DEFINED_MASK = 8'hF9;

	// ------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------
	localparam logic [3:0]  CTRL_OFS     = 4'h0;
	localparam logic [3:0]  ADDR_OFS     = 4'h4;
	localparam logic [3:0]  DATA_OFS     = 4'h8;
	localparam logic [3:0]  STAT_OFS     = 4'hC;
	localparam int          SUPPLY_EN    = 8;
	localparam int          ST_BUSY      = 8;
	localparam int          ST_ERR       = 9;
	localparam int          ST_SUPPLY    = 10;
	localparam int          ST_TOGGLING  = 11;
	localparam int          ST_VERIFY    = 12;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [2:0] {
		CMD_NONE  = 3'h0,
		CMD_SETUP = 3'h1,
		CMD_WORD  = 3'h2,
		CMD_FINAL = 3'h3,
		CMD_RESET = 3'h4,
		CMD_POLL  = 3'h5
	} cmd_e;

	typedef struct packed {
		logic [20:0] addr;
		logic [15:0] dq;
		logic        dq_oe_n;
		logic        chip_en_n;
		logic        read_en_n;
		logic        supply_on;
	} pins_s;

endpackage : otp_host_pkg

// File: verification/otp_dev_model.sv
// Behavioural model of the one-time-programmable memory behind the host.
module otp_dev_model
	import otp_host_pkg::*;
#(
	parameter int WAIT_READS = 2
)
(
	// Memory pins
	input  pins_s            pins,
	output wire logic [15:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	logic [15:0] mem [16];
	logic [2:0]  mode   = 3'h0;
	logic        first  = 1'b0;
	logic        tog    = 1'b0;
	logic        fail   = 1'b0;
	logic        vfail  = 1'b0;
	logic        poll7  = 1'b0;
	logic [3:0]  ptr    = 4'h0;
	logic [3:0]  region = 4'h0;
	int          wcnt   = 0;
	int          bad    = 0;
	wire logic [7:0]  stat = {poll7, tog, fail, vfail, 3'h0,
		((wcnt != 0) || fail)};
	wire logic [15:0] rdv = (mode >= 3'h4) ? {8'h00, stat} :
		mem[pins.addr[3:0]];
	// Released bus shows the inverse so a stale sample is never mistaken.
	assign dq_in = (!pins.chip_en_n && !pins.read_en_n) ? rdv : ~rdv;

	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
	end

	always @(posedge pins.chip_en_n) begin
		if (pins.dq_oe_n === 1'b0) begin
			wr(pins.addr, pins.dq);
		end else if (pins.dq_oe_n === 1'b1 && mode >= 3'h4) begin
			tog = !tog;
			if (wcnt != 0) wcnt--;
		end
	end

	task automatic wr(input logic [20:0] a, input logic [15:0] d);
		if (mode == 3'h6) begin
			if (d[7:0] == 8'hF0) begin
				mode = 3'h0;
				fail = 1'b0;
				vfail = 1'b0;
			end
		end else if (mode >= 3'h4) begin
			if (!pins.supply_on) begin
				vfail = 1'b1;
				fail = 1'b1;
				mode = 3'h6;
			end else if (first || a[20:17] == region) begin
				if (wcnt != 0) bad++;
				poll7 = !d[7];
				if (first) begin
					region = a[20:17];
					ptr = a[3:0];
				end else begin
					ptr++;
				end
				first = 1'b0;
				wcnt = WAIT_READS;
				if (mode == 3'h4) begin
					if ((mem[ptr] & d) != d) fail = 1'b1;
					mem[ptr] = mem[ptr] & d;
				end else if (mem[ptr] != d) begin
					fail = 1'b1;
				end
				if (fail) mode = 3'h6;
			end else begin
				first = 1'b1;
				mode = (mode == 3'h4) ? 3'h5 : 3'h0;
			end
		end else if (a[10:0] == 11'h555 && d[7:0] == 8'hAA && mode == 3'h0) begin
			mode = 3'h1;
		end else if (a[10:0] == 11'h2AA && d[7:0] == 8'h55 && mode == 3'h1) begin
			mode = 3'h2;
		end else if (a[10:0] == 11'h555 && d[7:0] == 8'h20 && mode == 3'h2
			&& pins.supply_on) begin
			mode = 3'h4;
			first = 1'b1;
		end else begin
			mode = 3'h0;
		end
	endtask : wr
endmodule : otp_dev_model

// File: verification/tb_otp_mwp_host.sv
// Self-checking bench for the multiple-word programming host.
module tb_otp_mwp_host
	import otp_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr  = 4'h0;
	logic [3:0]  araddr  = 4'h0;
	logic [3:0]  wstrb   = 4'hF;
	logic [31:0] wdata   = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	wire logic   awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	pins_s            pins;
	wire logic [15:0] dq_in;
	int          n_fail = 0;
	int          checks_done = 0;
	logic [31:0] rd;
	logic [1:0]  rs;
	logic [15:0] pat [3] = '{16'hA5A5, 16'h0F0F, 16'h1234};

	always #5 aclk = ~aclk;

	otp_mwp_host otp_mwp_host_inst (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.pins, .dq_in);
	otp_dev_model otp_dev_model_inst (.pins, .dq_in);

	task automatic chk(input string nm, input logic [31:0] e, s);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task automatic hang();
		n_fail++;
		report_and_stop();
	endtask : hang

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(negedge aclk);
			ta = awready && awvalid;
			tw = wready && wvalid;
			tb = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : wr

	task automatic rd_reg(input logic [3:0] a);
		logic ta, tr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(negedge aclk);
			ta = arready && arvalid;
			tr = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) begin
				rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : rd_reg

	task automatic cmd(input cmd_e c, input logic sup);
		wr(CTRL_OFS, {23'h0, sup, 5'h0, c});
		for (int i = 0; i < 400; i++) begin
			rd_reg(STAT_OFS);
			if (rd[ST_BUSY] === 1'b0) return;
		end
		hang();
	endtask : cmd

	task automatic word(input logic [20:0] a, input logic [15:0] d,
		input logic sup);
		wr(ADDR_OFS, {11'h0, a});
		wr(DATA_OFS, {16'h0, d});
		cmd(CMD_WORD, sup);
	endtask : word

	task automatic t_regs();
		rd_reg(STAT_OFS);
		chk("stat_reset", 32'h0, rd);
		rd_reg(4'h2);
		chk("misaligned_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		wr(STAT_OFS, 32'hFFFF_FFFF);
		chk("stat_write_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		$display("t_regs done");
	endtask : t_regs

	task automatic t_prog();
		cmd(CMD_SETUP, 1'b1);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 3; i++) word(21'h4, pat[i], 1'b1);
			cmd(CMD_FINAL, 1'b1);
			rd_reg(STAT_OFS);
			if (p == 0) begin
				chk("verify_phase", 32'h1, {31'h0, rd[ST_VERIFY]});
				chk("toggling", 32'h1, {31'h0, rd[ST_TOGGLING]});
				chk("poll_bit", 32'h1, {31'h0, rd[7]});
			end
		end
		cmd(CMD_POLL, 1'b1);
		rd_reg(STAT_OFS);
		chk("exit_status", 32'h0, {29'h0, rd[ST_SUPPLY:ST_BUSY]});
		chk("supply_bit", 32'h0, {31'h0, rd[SUPPLY_BIT]});
		for (int i = 0; i < 3; i++)
			chk("array_word", {16'h0, pat[i]}, {16'h0, otp_dev_model_inst.mem[4 + i]});
		chk("poll_before_write", 32'h0, otp_dev_model_inst.bad);
		chk("read_mode", 32'h0, {29'h0, otp_dev_model_inst.mode});
		$display("t_prog done");
	endtask : t_prog

	task automatic t_zero();
		cmd(CMD_SETUP, 1'b1);
		word(21'h4, 16'hFFFF, 1'b1);
		word(21'h4, 16'h0000, 1'b1);
		rd_reg(STAT_OFS);
		chk("err_latch", 32'h1, {31'h0, rd[ST_ERR]});
		chk("fail_bit", 32'h1, {31'h0, rd[FAIL_BIT]});
		chk("wait_bit", 32'h1, {31'h0, rd[WAIT_BIT]});
		chk("zero_bit", 32'h0, {31'h0, rd[3]});
		cmd(CMD_SETUP, 1'b1);
		chk("no_cmd_in_error", 32'h6, {29'h0, otp_dev_model_inst.mode});
		cmd(CMD_RESET, 1'b1);
		rd_reg(STAT_OFS);
		chk("err_cleared", 32'h0, {31'h0, rd[ST_ERR]});
		chk("zero_kept", 32'hA5A5, {16'h0, otp_dev_model_inst.mem[4]});
		$display("t_zero done");
	endtask : t_zero

	task automatic t_supply();
		cmd(CMD_SETUP, 1'b1);
		word(21'h8, 16'h00FF, 1'b0);
		word(21'h8, 16'h00FF, 1'b0);
		rd_reg(STAT_OFS);
		chk("supply_latch", 32'h1, {31'h0, rd[ST_SUPPLY]});
		chk("supply_bit", 32'h1, {31'h0, rd[SUPPLY_BIT]});
		chk("aborted_word", 32'hFFFF, {16'h0, otp_dev_model_inst.mem[8]});
		cmd(CMD_RESET, 1'b1);
		rd_reg(STAT_OFS);
		chk("supply_cleared", 32'h0, {31'h0, rd[ST_SUPPLY]});
		$display("t_supply done");
	endtask : t_supply

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_prog();
		t_zero();
		t_supply();
		report_and_stop();
	end
endmodule : tb_otp_mwp_host
